// ==== verilog/timer45_consts.vh ====
// constants for the timer 4/5 count and capture/reload register block
`ifndef TIMER45_CONSTS_VH
`define TIMER45_CONSTS_VH
`define T45_PAGE          8'h10
`define T5_CAPL_ADDR      8'h92
`define T5_CAPH_ADDR      8'h93
`define T5_CNTL_ADDR      8'h94
`define T5_CNTH_ADDR      8'h95
`define T4_CAPL_ADDR      8'hCA
`define T4_CAPH_ADDR      8'hCB
`define T4_CNTL_ADDR      8'hCC
`define T4_CNTH_ADDR      8'hCD
`define T45_RESET_VAL     8'h00
`define CLKSEL_DIV12      2'b00
`define CLKSEL_SYS        2'b01
`define CLKSEL_EXT8       2'b10
`define CLKSEL_DIV2       2'b11
`define DIV12_LAST        4'hB
`define EXT_DIV_LAST      3'h7
`endif

// ==== verilog/timer45_regs.v ====
// timers 4 and 5: count and capture/reload registers with counting logic
`include "timer45_consts.vh"
`default_nettype none
module timer45_regs (
	// clock and reset
	input  wire       core_clk_i,
	input  wire       sys_rst_i,
	// special function register port
	input  wire [7:0] sfr_page_i,
	input  wire [7:0] sfr_addr_i,
	input  wire       sfr_wr_i,
	input  wire       sfr_rd_i,
	input  wire [7:0] sfr_wdata_i,
	output reg  [7:0] sfr_rdata_o,
	// per-timer configuration, index 0 is timer 4, index 1 is timer 5
	input  wire [1:0] run_i,
	input  wire [1:0] split_8bit_i,
	input  wire [1:0] capture_mode_i,
	input  wire [1:0] capture_trig_i,
	input  wire [3:0] timer_clock_select_i,
	input  wire [1:0] decrement_enable_i,
	// pins
	input  wire [1:0] external_direction_input_i,
	input  wire       ext_clk_i,
	// overflow pulses
	output wire [1:0] ovf_lo_o,
	output wire [1:0] ovf_hi_o
);
	// per-timer bytes gathered for the read mux, timer 4 in bits 7:0
	// and timer 5 in bits 15:8; each byte is driven from its own scope
	wire [15:0] cnt_lo_all;
	wire [15:0] cnt_hi_all;
	wire [15:0] cap_lo_all;
	wire [15:0] cap_hi_all;
	// input synchronisers: first stage read only by second
	reg [1:0] dir_s1_q, dir_s2_q;
	reg [1:0] cap_s1_q, cap_s2_q, cap_s3_q;
	reg       ext_s1_q, ext_s2_q, ext_s3_q;
	// prescalers
	reg [3:0] div12_q;
	reg       div2_q;
	reg [2:0] ext_div_q;
	// tick enables
	wire tick_div12 = (div12_q == `DIV12_LAST);
	wire tick_ext8  = ext_s2_q & ~ext_s3_q & (ext_div_q == `EXT_DIV_LAST);
	wire page_ok    = (sfr_page_i == `T45_PAGE);

	// pick tick source from the two select bits
	function tick_sel;
		input [1:0] sel;
		input       d12;
		input       d2;
		input       e8;
		begin
			case (sel)
				`CLKSEL_DIV12: tick_sel = d12;
				`CLKSEL_SYS:   tick_sel = 1'b1;
				`CLKSEL_EXT8:  tick_sel = e8;
				`CLKSEL_DIV2:  tick_sel = d2;
				default:       tick_sel = 1'b0;
			endcase
		end
	endfunction

	// synchronisers and prescalers
	always @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			dir_s1_q  <= 2'b00;
			dir_s2_q  <= 2'b00;
			cap_s1_q  <= 2'b00;
			cap_s2_q  <= 2'b00;
			cap_s3_q  <= 2'b00;
			ext_s1_q  <= 1'b0;
			ext_s2_q  <= 1'b0;
			ext_s3_q  <= 1'b0;
			div12_q   <= 4'h0;
			div2_q    <= 1'b0;
			ext_div_q <= 3'h0;
		end else begin
			// direction pin, two flops before any logic reads it
			dir_s1_q <= external_direction_input_i;
			dir_s2_q <= dir_s1_q;
			// capture pin, third flop only to find the rising edge
			cap_s1_q <= capture_trig_i;
			cap_s2_q <= cap_s1_q;
			cap_s3_q <= cap_s2_q;
			// external clock, third flop only to find the rising edge
			ext_s1_q <= ext_clk_i;
			ext_s2_q <= ext_s1_q;
			ext_s3_q <= ext_s2_q;
			// prescalers run free and are shared by both timers, so the
			// first tick after enabling may come up to one period early
			div12_q  <= tick_div12 ? 4'h0 : div12_q + 4'h1;
			div2_q   <= ~div2_q;
			// external clock divided by 8 on synchronised rising edges
			if (ext_s2_q & ~ext_s3_q)
				ext_div_q <= ext_div_q + 3'h1;
		end
	end

	// step a byte by one in the chosen direction; shared by both halves
	// of a split timer so the two byte timers behave alike
	function [7:0] step8;
		input [7:0] val;
		input       dn;
		begin
			if (dn)
				step8 = val - 8'h01;
			else
				step8 = val + 8'h01;
		end
	endfunction

	// step the joined 16-bit count by one in the chosen direction
	function [15:0] step16;
		input [15:0] val;
		input        dn;
		begin
			if (dn)
				step16 = val - 16'h0001;
			else
				step16 = val + 16'h0001;
		end
	endfunction

	// end of range for the direction: all ones going up, zero going down
	function at_end8;
		input [7:0] val;
		input       dn;
		begin
			if (dn)
				at_end8 = (val == 8'h00);
			else
				at_end8 = (val == 8'hFF);
		end
	endfunction

	// counters, captures, reloads and register writes, one scope per timer;
	// each timer keeps its own registers so every flop has a single driver
	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : tmr
			// register addresses of this timer
			localparam [7:0] A_CAPL = (g == 0) ? `T4_CAPL_ADDR : `T5_CAPL_ADDR;
			localparam [7:0] A_CAPH = (g == 0) ? `T4_CAPH_ADDR : `T5_CAPH_ADDR;
			localparam [7:0] A_CNTL = (g == 0) ? `T4_CNTL_ADDR : `T5_CNTL_ADDR;
			localparam [7:0] A_CNTH = (g == 0) ? `T4_CNTH_ADDR : `T5_CNTH_ADDR;

			// live count bytes and their next values
			reg  [7:0]  cnt_lo_q;
			reg  [7:0]  cnt_hi_q;
			reg  [7:0]  cnt_lo_d;
			reg  [7:0]  cnt_hi_d;
			// capture/reload byte pair and its next values
			reg  [7:0]  cap_lo_q;
			reg  [7:0]  cap_hi_q;
			reg  [7:0]  cap_lo_d;
			reg  [7:0]  cap_hi_d;
			// one-cycle overflow pulses and their next values
			reg         ovf_lo_q;
			reg         ovf_hi_q;
			reg         ovf_lo_d;
			reg         ovf_hi_d;

			// software write strobes, honoured only on the timer page
			wire        wr_ok  = sfr_wr_i & page_ok;
			wire        wr_cl  = wr_ok & (sfr_addr_i == A_CNTL);
			wire        wr_ch  = wr_ok & (sfr_addr_i == A_CNTH);
			wire        wr_pl  = wr_ok & (sfr_addr_i == A_CAPL);
			wire        wr_ph  = wr_ok & (sfr_addr_i == A_CAPH);
			// count enable from the selected prescaler
			wire        tick   = run_i[g] &
				tick_sel(timer_clock_select_i[2*g+1:2*g], tick_div12, div2_q, tick_ext8);
			// counting down only with decrement enabled and direction low
			wire        down   = decrement_enable_i[g] & ~dir_s2_q[g];
			// joined count and its next value in 16-bit mode
			wire [15:0] c16    = {cnt_hi_q, cnt_lo_q};
			wire [15:0] n16    = step16(c16, down);
			// end-of-range flags for each byte and for the pair
			wire        end_l  = at_end8(cnt_lo_q, down);
			wire        end_h  = at_end8(cnt_hi_q, down);
			wire        ovf16  = end_l & end_h;
			// synchronised rising edge of the capture input
			wire        cap_ev = capture_mode_i[g] & cap_s2_q[g] & ~cap_s3_q[g];
			// reload only in 16-bit auto-reload mode at the end of range
			wire        reload = ~split_8bit_i[g] & ~capture_mode_i[g] & ovf16;

			// next state: counting first, then capture, then software writes
			always @* begin
				// hold counts and pair, clear both overflow pulses, unless an event below changes them
				cnt_lo_d = cnt_lo_q;
				cnt_hi_d = cnt_hi_q;
				cap_lo_d = cap_lo_q;
				cap_hi_d = cap_hi_q;
				ovf_lo_d = 1'b0;
				ovf_hi_d = 1'b0;
				if (tick) begin
					if (split_8bit_i[g]) begin
						// two independent byte timers, each wraps on its own
						cnt_lo_d = step8(cnt_lo_q, down);
						cnt_hi_d = step8(cnt_hi_q, down);
						ovf_lo_d = end_l;
						ovf_hi_d = end_h;
					end else if (reload) begin
						// reload pair supplies the new count
						cnt_lo_d = cap_lo_q;
						cnt_hi_d = cap_hi_q;
						ovf_hi_d = 1'b1;
					end else begin
						// one 16-bit count; in capture mode it wraps freely
						cnt_lo_d = n16[7:0];
						cnt_hi_d = n16[15:8];
						ovf_hi_d = ovf16;
					end
				end
				// snapshot of the live count on a capture edge
				if (cap_ev) begin
					cap_lo_d = cnt_lo_q;
					cap_hi_d = cnt_hi_q;
				end
				// software writes to the count win over counting
				if (wr_cl)
					cnt_lo_d = sfr_wdata_i;
				if (wr_ch)
					cnt_hi_d = sfr_wdata_i;
				// a capture edge wins over a write to the pair, so a
				// snapshot taken in the same cycle is never lost
				if (wr_pl & ~cap_ev)
					cap_lo_d = sfr_wdata_i;
				if (wr_ph & ~cap_ev)
					cap_hi_d = sfr_wdata_i;
			end

			// state flops of this timer
			always @(posedge core_clk_i) begin
				if (sys_rst_i) begin
					cnt_lo_q <= `T45_RESET_VAL;
					cnt_hi_q <= `T45_RESET_VAL;
					cap_lo_q <= `T45_RESET_VAL;
					cap_hi_q <= `T45_RESET_VAL;
					ovf_lo_q <= 1'b0;
					ovf_hi_q <= 1'b0;
				end else begin
					cnt_lo_q <= cnt_lo_d;
					cnt_hi_q <= cnt_hi_d;
					cap_lo_q <= cap_lo_d;
					cap_hi_q <= cap_hi_d;
					ovf_lo_q <= ovf_lo_d;
					ovf_hi_q <= ovf_hi_d;
				end
			end

			// hand the bytes to the shared read mux, pulses to the outputs
			assign cnt_lo_all[8*g+7:8*g] = cnt_lo_q;
			assign cnt_hi_all[8*g+7:8*g] = cnt_hi_q;
			assign cap_lo_all[8*g+7:8*g] = cap_lo_q;
			assign cap_hi_all[8*g+7:8*g] = cap_hi_q;
			assign ovf_lo_o[g]           = ovf_lo_q;
			assign ovf_hi_o[g]           = ovf_hi_q;
		end
	endgenerate

	// registered read data; zero off page, on unmapped addresses and
	// between reads, so a stray strobe never shows a stale byte
	always @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			sfr_rdata_o <= 8'h00;
		end else if (sfr_rd_i & page_ok) begin
			case (sfr_addr_i)
				// timer 4 pair and count
				`T4_CAPL_ADDR: sfr_rdata_o <= cap_lo_all[7:0];
				`T4_CAPH_ADDR: sfr_rdata_o <= cap_hi_all[7:0];
				`T4_CNTL_ADDR: sfr_rdata_o <= cnt_lo_all[7:0];
				`T4_CNTH_ADDR: sfr_rdata_o <= cnt_hi_all[7:0];
				// timer 5 pair and count
				`T5_CAPL_ADDR: sfr_rdata_o <= cap_lo_all[15:8];
				`T5_CAPH_ADDR: sfr_rdata_o <= cap_hi_all[15:8];
				`T5_CNTL_ADDR: sfr_rdata_o <= cnt_lo_all[15:8];
				`T5_CNTH_ADDR: sfr_rdata_o <= cnt_hi_all[15:8];
				// unmapped address on the timer page
				default:       sfr_rdata_o <= 8'h00;
			endcase
		end else begin
			// idle or another page
			sfr_rdata_o <= 8'h00;
		end
	end
endmodule
`default_nettype wire

// ==== tb/timer45_regs_chk.sv ====
// checker: register port and overflow relations of the timer 4/5 block
`default_nettype none
module timer45_chk (
	// clock and reset
	input wire logic       core_clk_i,
	input wire logic       sys_rst_i,
	// register port
	input wire logic [7:0] sfr_page_i,
	input wire logic [7:0] sfr_addr_i,
	input wire logic       sfr_wr_i,
	input wire logic       sfr_rd_i,
	input wire logic [7:0] sfr_wdata_i,
	input wire logic [7:0] sfr_rdata_o,
	// configuration and overflow
	input wire logic [1:0] run_i,
	input wire logic [1:0] split_8bit_i,
	input wire logic [1:0] capture_mode_i,
	input wire logic [1:0] ovf_lo_o,
	input wire logic [1:0] ovf_hi_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (sys_rst_i);
	// accepted write and read on the timer page
	sequence s_wr(a, c);
		c && sfr_wr_i && !sfr_rd_i && sfr_page_i == 8'h10 && sfr_addr_i == a;
	endsequence
	sequence s_rd(a, c);
		c && sfr_rd_i && !sfr_wr_i && sfr_page_i == 8'h10 && sfr_addr_i == a;
	endsequence
	// write, idle, read back returns the written byte
	property p_echo(a, c);
		s_wr(a, c) ##1 (c && !sfr_wr_i) ##1 s_rd(a, c) |=> sfr_rdata_o == $past(sfr_wdata_i, 3);
	endproperty
	a_cap_low_echo: assert property (p_echo(8'hCA, !capture_mode_i[0]))
		else $error("capture low byte readback wrong");
	a_cap_high_echo: assert property (p_echo(8'h93, !capture_mode_i[1]))
		else $error("capture high byte readback wrong");
	a_count_low_echo: assert property (p_echo(8'hCC, !run_i[0]))
		else $error("count low readback wrong");
	a_count_high_echo: assert property (p_echo(8'h95, !run_i[1]))
		else $error("count high readback wrong");
	a_read_idle_zero: assert property (!sfr_rd_i |=> sfr_rdata_o == 8'h00)
		else $error("read data not zero when idle");
	a_off_page_zero: assert property (sfr_page_i != 8'h10 |=> sfr_rdata_o == 8'h00)
		else $error("answer off the timer page");
	a_lo_split_only: assert property (ovf_lo_o[0] |-> $past(split_8bit_i[0]))
		else $error("low overflow outside 8-bit mode");
	a_stop_no_ovf: assert property (!run_i[1] [*4] |-> !ovf_hi_o[1])
		else $error("overflow while stopped");
endmodule
bind timer45_regs timer45_chk timer45_chk_i (.core_clk_i, .sys_rst_i, .sfr_page_i,
	.sfr_addr_i, .sfr_wr_i, .sfr_rd_i, .sfr_wdata_i, .sfr_rdata_o, .run_i,
	.split_8bit_i, .capture_mode_i, .ovf_lo_o, .ovf_hi_o);
`default_nettype wire

// ==== tb/timer45_regs_tb.sv ====
// bench: register access and counting of the timer 4/5 block
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fails++; $display("BAD %0t got %h exp %h", $time, g, e); end end
module timer45_regs_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic       clk = 0, rst = 1, wr = 0, rd = 0;
	logic [7:0] pg = 8'h10, ad = 0, wd = 0, q, v;
	logic [1:0] run = 0, spl = 0, cap = 0, trig = 0, dec = 0, dir = 2'b11;
	logic [3:0] sel = 4'h5;
	logic       ext = 0;
	logic [1:0] ovl, ovh;
	int         nlo = 0, nhi = 0;
	int         fails = 0, checks = 0;
	always #10 clk = ~clk;
	// free external clock, one rising edge every two cycles
	always @(posedge clk) ext <= ~ext;
	// count overflow pulses: timer 4 low byte, timer 5 high byte
	always @(posedge clk) begin
		if (ovl[0] === 1'b1) nlo++;
		if (ovh[1] === 1'b1) nhi++;
	end
	timer45_regs timer45_regs_i (.core_clk_i(clk), .sys_rst_i(rst), .sfr_page_i(pg),
		.sfr_addr_i(ad), .sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_wdata_i(wd), .sfr_rdata_o(q),
		.run_i(run), .split_8bit_i(spl), .capture_mode_i(cap), .capture_trig_i(trig),
		.timer_clock_select_i(sel), .decrement_enable_i(dec),
		.external_direction_input_i(dir), .ext_clk_i(ext), .ovf_lo_o(ovl), .ovf_hi_o(ovh));
	// one register write, strobe held for a single edge
	task automatic w(input logic [7:0] a, d);
		@(posedge clk) begin wr <= 1; ad <= a; wd <= d; end
		@(posedge clk) wr <= 0;
	endtask
	// one register read, data taken in the cycle after the strobe
	task automatic r(input logic [7:0] a);
		@(posedge clk) begin rd <= 1; ad <= a; end
		@(posedge clk) rd <= 0;
		#1 v = q;
	endtask
	// run the chosen timers for a fixed number of cycles
	task automatic tick(input logic [1:0] rn, input int c);
		@(posedge clk) run <= rn;
		repeat (c) @(posedge clk);
		run <= 0;
	endtask
	task automatic conclude;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	initial begin #400000; fails++; conclude(); end
	initial begin
		logic [7:0] ads[8] = '{8'h92, 8'h93, 8'h94, 8'h95, 8'hCA, 8'hCB, 8'hCC, 8'hCD};
		logic [1:0] ks[4] = '{2'b00, 2'b01, 2'b11, 2'b10};
		int         es[4] = '{20, 240, 120, 15};
		repeat (20) @(posedge clk);
		rst <= 0;
		foreach (ads[i]) begin r(ads[i]); `CHK(v, 8'h00) end
		foreach (ads[i]) begin w(ads[i], 8'(i * 17 + 1)); r(ads[i]); `CHK(v, 8'(i * 17 + 1)) end
		@(posedge clk) pg <= 8'h00;
		w(8'hCC, 8'hAA);
		r(8'hCC);
		`CHK(v, 8'h00)
		@(posedge clk) pg <= 8'h10;
		r(8'hCC);
		`CHK(v, 8'h67)
		r(8'h90);
		`CHK(v, 8'h00)
		$display("end access");
		foreach (ks[k]) begin
			@(posedge clk) sel <= {2'b01, ks[k]};
			w(8'hCC, 8'h00);
			w(8'hCD, 8'h00);
			tick(2'b01, 240);
			r(8'hCC);
			`CHK(v inside {[es[k] - 2 : es[k] + 2]}, 1'b1)
		end
		$display("end clock select");
		@(posedge clk) begin sel <= 4'h5; dec <= 2'b01; dir <= 2'b10; end
		w(8'hCC, 8'h01);
		w(8'hCD, 8'h12);
		tick(2'b01, 10);
		r(8'hCD);
		`CHK(v, 8'h11)
		@(posedge clk) dec <= 2'b00;
		tick(2'b01, 20);
		r(8'hCD);
		`CHK(v, 8'h12)
		@(posedge clk) spl <= 2'b01;
		w(8'hCC, 8'hF8);
		tick(2'b01, 20);
		r(8'hCD);
		`CHK(v inside {[8'h24 : 8'h28]}, 1'b1)
		`CHK(nlo, 1)
		$display("end direction and split");
		w(8'h92, 8'h34);
		w(8'h93, 8'h12);
		w(8'h94, 8'hFE);
		w(8'h95, 8'hFF);
		tick(2'b10, 10);
		r(8'h95);
		`CHK(v, 8'h12)
		`CHK(nhi, 1)
		w(8'hCD, 8'h77);
		@(posedge clk) cap <= 2'b01;
		@(posedge clk) trig <= 2'b01;
		repeat (6) @(posedge clk);
		r(8'hCB);
		`CHK(v, 8'h77)
		$display("end reload and capture");
		conclude();
	end
endmodule
`default_nettype wire
